// *** rtl/tpcm_pkg.sv ***
// Shared constants and types for the telemetry commutator and serial encoder.
// Function
// - Sample sixteen high-level channels at 1.25 per second into the prime stage.
// - Sample nineteen two-state inputs at 10 per second, forward to prime stage.
// - Prime stage samples three high-level channels at 40 per second each.
// - Master stage samples five low-level channels at 640 per second each.
// - Master stage samples three more low-level channels at 80 per second.
// - Every selected sample is digitised and handed to the output shifter.
// - Output is a gapless NRZ stream at 51.2 kbit/s.
// - Line is high for a one and low for a zero across each bit.
// - All sampling gates come from counter chains on the crystal clock.
// - No digital word sampling and no playback recording are performed.
// - Primary and secondary body rates share one channel, picked by ground command.
package tpcm_pkg;
    // Clock and line rate; the bit period rounds down to whole cycles.
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned BIT_RATE_BPS = 51_200;
    localparam int unsigned BIT_CLKS_DFLT = CLK_HZ / BIT_RATE_BPS;
    localparam int unsigned DIV_W = 13;
    // Word and frame geometry.
    localparam int unsigned WORD_W = 8;
    localparam int unsigned BIT_IDX_W = 3;
    localparam int unsigned SLOT_W = 4;
    localparam int unsigned FRAME_W = 9;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned NUM_DISC = 19;
    localparam logic [SLOT_W-1:0] SLOT_SYNC = 4'h0;
    localparam logic [SLOT_W-1:0] SLOT_LL_FIRST = 4'h1;
    localparam logic [SLOT_W-1:0] SLOT_LL_LAST = 4'h5;
    localparam logic [SLOT_W-1:0] SLOT_PRIME = 4'h6;
    localparam logic [SLOT_W-1:0] SLOT_SLOW = 4'h7;
    localparam logic [SLOT_W-1:0] SLOT_PID = 4'h8;
    localparam logic [SLOT_W-1:0] SLOT_LAST = 4'h9;
    // Prime subframe positions (one master frame each, 64 per prime cycle).
    localparam logic [5:0] POS_PSYNC = 6'h00;
    localparam logic [3:0] POS_RATE_FIRST = 4'h1;
    localparam logic [3:0] POS_RATE_LAST = 4'h3;
    localparam logic [5:0] POS_DISC_A = 6'h04;
    localparam logic [5:0] POS_DISC_B = 6'h05;
    localparam logic [5:0] POS_DISC_C = 6'h06;
    localparam logic [5:0] POS_HSUB_A = 6'h07;
    localparam logic [5:0] POS_HSUB_B = 6'h27;
    localparam logic [2:0] SLOW_LAST = 3'h2;
    // Fixed words.
    localparam logic [WORD_W-1:0] FRAME_SYNC = 8'hE4;
    localparam logic [WORD_W-1:0] PRIME_SYNC = 8'h1B;
    localparam logic [WORD_W-1:0] FILL_WORD = 8'h55;
    // Analog multiplexer select codes.
    localparam int unsigned MUX_W = 5;
    localparam logic [MUX_W-1:0] MUX_LL_FAST = 5'h00;
    localparam logic [MUX_W-1:0] MUX_LL_SLOW = 5'h05;
    localparam logic [MUX_W-1:0] MUX_HL_RATE = 5'h08;
    localparam logic [MUX_W-1:0] MUX_HL_SUB = 5'h10;
    // Bit position of the latched command execute input.
    localparam int unsigned DISC_EXEC = 8;
    // Sampler states.
    typedef enum logic [2:0] {
        SMP_IDLE = 3'b001,
        SMP_CONV = 3'b010,
        SMP_PUSH = 3'b100
    } tpcm_smp_type;
endpackage

// *** rtl/tpcm_fifo.sv ***
// Word FIFO between the sampler and the output shifter.
`timescale 1ns/1ps
`default_nettype none
module tpcm_fifo import tpcm_pkg::*; #(
    parameter int unsigned WIDTH = WORD_W,
    parameter int unsigned DEPTH = FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Fill side.
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side.
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int unsigned PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [PTR_W:0] wr_q, wr_d, rd_q, rd_d;
    logic full, empty, do_wr, do_rd;

    // An extra pointer bit tells full from empty without a counter.
    assign full = (wr_q[PTR_W] != rd_q[PTR_W]) && (wr_q[PTR_W-1:0] == rd_q[PTR_W-1:0]);
    assign empty = (wr_q == rd_q);
    assign do_wr = in_valid_i && !full;
    assign do_rd = out_ready_i && !empty;
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem_q[rd_q[PTR_W-1:0]];

    // Next pointers and storage.
    always_comb
    begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        if (do_wr)
        begin
            mem_d[wr_q[PTR_W-1:0]] = in_data_i;
            wr_d = wr_q + 1'b1;
        end
        if (do_rd)
        begin
            rd_d = rd_q + 1'b1;
        end
    end

    // Register stage.
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_q[i] <= '0;
            end
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            mem_q <= mem_d;
        end
    end
endmodule
`default_nettype wire

// *** rtl/tpcm_timing.sv ***
// Counter chain that times bits, word slots and frames from the core clock.
`timescale 1ns/1ps
`default_nettype none
module tpcm_timing import tpcm_pkg::*; #(
    parameter int unsigned BIT_CLKS = BIT_CLKS_DFLT
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Timing outputs.
    output logic bit_tick_o,
    output logic word_tick_o,
    output logic [BIT_IDX_W-1:0] bit_idx_o,
    output logic [SLOT_W-1:0] slot_o,
    output logic [FRAME_W-1:0] frame_o
);
    logic [DIV_W-1:0] div_q, div_d;
    logic [BIT_IDX_W-1:0] bit_q, bit_d;
    logic [SLOT_W-1:0] slot_q, slot_d;
    logic [FRAME_W-1:0] frame_q, frame_d;
    logic btick_q, btick_d, wtick_q, wtick_d;

    // Divider to bit rate, then bit, slot and frame counters in a chain.
    always_comb
    begin
        div_d = div_q + 1'b1;
        bit_d = bit_q;
        slot_d = slot_q;
        frame_d = frame_q;
        btick_d = 1'b0;
        wtick_d = 1'b0;
        if (div_q == DIV_W'(BIT_CLKS - 1))
        begin
            div_d = '0;
            btick_d = 1'b1;
            bit_d = bit_q + 1'b1;
            if (bit_q == BIT_IDX_W'(WORD_W - 1))
            begin
                wtick_d = 1'b1;
                slot_d = (slot_q == SLOT_LAST) ? SLOT_SYNC : slot_q + 1'b1;
                if (slot_q == SLOT_LAST)
                begin
                    frame_d = frame_q + 1'b1;
                end
            end
        end
    end

    // Register stage.
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            div_q <= '0;
            bit_q <= '1;
            slot_q <= SLOT_LAST;
            frame_q <= '1;
            btick_q <= 1'b0;
            wtick_q <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            bit_q <= bit_d;
            slot_q <= slot_d;
            frame_q <= frame_d;
            btick_q <= btick_d;
            wtick_q <= wtick_d;
        end
    end

    assign bit_tick_o = btick_q;
    assign word_tick_o = wtick_q;
    assign bit_idx_o = bit_q;
    assign slot_o = slot_q;
    assign frame_o = frame_q;

    // Ticks are single-cycle and well apart.
    a_bit_spacing: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        btick_q |=> !btick_q [*8]) else $error("bit ticks too close");
    a_word_on_bit0: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        wtick_q |-> btick_q && bit_q == '0) else $error("word tick off bit zero");
endmodule
`default_nettype wire

// *** rtl/tpcm_top.sv ***
// Telemetry commutation tree, converter control and NRZ serial output.
`timescale 1ns/1ps
`default_nettype none
module tpcm_top import tpcm_pkg::*; #(
    parameter int unsigned BIT_CLKS = BIT_CLKS_DFLT
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Two-state discrete inputs from switches and relays.
    input wire logic vehicle_separated_i,
    input wire logic cone_unlatched_i,
    input wire logic cone_locked_i,
    input wire logic craft_detached_i,
    input wire logic launch_config_ok_i,
    input wire logic shroud_jettisoned_i,
    input wire logic igniter_safe_i,
    input wire logic igniter_armed_i,
    input wire logic cmd_execute_pulse_i,
    input wire logic thruster_ring_sel_i,
    input wire logic [7:0] thruster_fire_n_i,
    input wire logic antenna_extended_i,
    // Body-rate source selection from the ground command link.
    input wire logic ground_command_link_rate_sel_i,
    output logic rate_src_sel_o,
    // Analog multiplexer and converter.
    output logic adc_start_o,
    output logic [MUX_W-1:0] adc_mux_o,
    input wire logic adc_valid_i,
    input wire logic [WORD_W-1:0] adc_data_i,
    // Unused digital selector and recorder paths.
    output logic digital_sel_en_o,
    output logic recorder_en_o,
    // Serial line to the transmitter.
    output logic nrz_data_o
);
    logic bit_tick, word_tick;
    logic [BIT_IDX_W-1:0] bit_idx;
    logic [SLOT_W-1:0] slot;
    logic [FRAME_W-1:0] frame;
    logic [5:0] pos;
    logic [2:0] minor;
    logic [3:0] hl_step;
    logic [NUM_DISC-1:0] disc_raw, disc_a_q, disc_b_q, disc_word;
    logic rate_a_q, rate_b_q, rate_q;
    logic exec_q, exec_d;
    tpcm_smp_type st_q, st_d;
    logic [WORD_W-1:0] word_q, word_d;
    logic [MUX_W-1:0] mux_q, mux_d;
    logic start_q, start_d;
    logic fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [WORD_W-1:0] fifo_out_data;
    logic [WORD_W-1:0] shift_q, shift_d;
    logic nrz_q, nrz_d;
    logic idle_off_q;

    // Counter chain gives all sampling gates.
    tpcm_timing #(
        .BIT_CLKS(BIT_CLKS)
    ) u_timing (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .bit_tick_o(bit_tick),
        .word_tick_o(word_tick),
        .bit_idx_o(bit_idx),
        .slot_o(slot),
        .frame_o(frame)
    );

    // Prime position, slow subframe step and high-level subcommutator step.
    assign pos = frame[5:0];
    assign minor = frame[2:0];
    assign hl_step = frame[8:5];

    // Discretes go straight to bits; levels keep their electrical sense.
    assign disc_raw = {antenna_extended_i, thruster_fire_n_i, thruster_ring_sel_i,
        cmd_execute_pulse_i, igniter_armed_i, igniter_safe_i, shroud_jettisoned_i,
        launch_config_ok_i, craft_detached_i, cone_locked_i, cone_unlatched_i,
        vehicle_separated_i};

    // Two-stage synchronisers for the discrete pins, three stages for the rate-select pin.
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            disc_a_q <= '0;
            disc_b_q <= '0;
            rate_a_q <= 1'b0;
            rate_b_q <= 1'b0;
            rate_q <= 1'b0;
            idle_off_q <= 1'b0;
        end
        else
        begin
            disc_a_q <= disc_raw;
            disc_b_q <= disc_a_q;
            rate_a_q <= ground_command_link_rate_sel_i;
            rate_b_q <= rate_a_q;
            rate_q <= rate_b_q;
            idle_off_q <= 1'b0;
        end
    end

    // The execute pulse is far shorter than a 10 per second sample, so it is
    // held until its word is taken; a pulse on the taking cycle is kept.
    always_comb
    begin
        disc_word = disc_b_q;
        disc_word[DISC_EXEC] = exec_q;
    end

    // Sampler: one word per slot, through the converter where analog.
    always_comb
    begin
        st_d = st_q;
        word_d = word_q;
        mux_d = mux_q;
        start_d = 1'b0;
        exec_d = exec_q;
        case (st_q)
            SMP_IDLE:
            begin
                if (word_tick)
                begin
                    st_d = SMP_PUSH;
                    word_d = FILL_WORD;
                    if (slot == SLOT_SYNC)
                    begin
                        word_d = FRAME_SYNC;
                    end
                    else if (slot <= SLOT_LL_LAST)
                    begin
                        st_d = SMP_CONV;
                        start_d = 1'b1;
                        mux_d = MUX_LL_FAST + MUX_W'(slot - SLOT_LL_FIRST);
                    end
                    else if (slot == SLOT_PRIME)
                    begin
                        if (pos == POS_PSYNC)
                        begin
                            word_d = PRIME_SYNC;
                        end
                        else if (pos[3:0] >= POS_RATE_FIRST && pos[3:0] <= POS_RATE_LAST)
                        begin
                            st_d = SMP_CONV;
                            start_d = 1'b1;
                            mux_d = MUX_HL_RATE + MUX_W'(pos[3:0] - POS_RATE_FIRST);
                        end
                        else if (pos == POS_DISC_A)
                        begin
                            word_d = disc_word[7:0];
                        end
                        else if (pos == POS_DISC_B)
                        begin
                            word_d = disc_word[15:8];
                            exec_d = 1'b0;
                        end
                        else if (pos == POS_DISC_C)
                        begin
                            word_d = WORD_W'(disc_word[NUM_DISC-1:16]);
                        end
                        else if (pos == POS_HSUB_A || pos == POS_HSUB_B)
                        begin
                            st_d = SMP_CONV;
                            start_d = 1'b1;
                            mux_d = MUX_HL_SUB + MUX_W'(hl_step);
                        end
                    end
                    else if (slot == SLOT_SLOW)
                    begin
                        if (minor <= SLOW_LAST)
                        begin
                            st_d = SMP_CONV;
                            start_d = 1'b1;
                            mux_d = MUX_LL_SLOW + MUX_W'(minor);
                        end
                    end
                    else if (slot == SLOT_PID)
                    begin
                        word_d = WORD_W'(pos);
                    end
                    else
                    begin
                        word_d = WORD_W'(hl_step);
                    end
                end
            end
            SMP_CONV:
            begin
                if (adc_valid_i)
                begin
                    word_d = adc_data_i;
                    st_d = SMP_PUSH;
                end
            end
            SMP_PUSH:
            begin
                if (fifo_in_ready)
                begin
                    st_d = SMP_IDLE;
                end
            end
            default:
            begin
                st_d = SMP_IDLE;
            end
        endcase
        if (disc_b_q[DISC_EXEC])
        begin
            exec_d = 1'b1;
        end
    end

    // Sampler registers.
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st_q <= SMP_IDLE;
            word_q <= '0;
            mux_q <= '0;
            start_q <= 1'b0;
            exec_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            word_q <= word_d;
            mux_q <= mux_d;
            start_q <= start_d;
            exec_q <= exec_d;
        end
    end

    // Sixteen words of slack absorb converter latency and back-pressure.
    tpcm_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(st_q == SMP_PUSH),
        .in_ready_o(fifo_in_ready),
        .in_data_i(word_q),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_out_data)
    );

    // Shifter loads at bit zero; an empty FIFO sends fill so the line never gaps.
    assign fifo_pop = bit_tick && (bit_idx == '0);
    always_comb
    begin
        shift_d = shift_q;
        nrz_d = nrz_q;
        if (bit_tick)
        begin
            if (bit_idx == '0)
            begin
                shift_d = fifo_out_valid ? fifo_out_data : FILL_WORD;
            end
            else
            begin
                shift_d = {shift_q[WORD_W-2:0], 1'b0};
            end
            nrz_d = shift_d[WORD_W-1];
        end
    end

    // Serial registers.
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            shift_q <= '0;
            nrz_q <= 1'b0;
        end
        else
        begin
            shift_q <= shift_d;
            nrz_q <= nrz_d;
        end
    end

    assign rate_src_sel_o = rate_q;
    assign adc_start_o = start_q;
    assign adc_mux_o = mux_q;
    assign digital_sel_en_o = idle_off_q;
    assign recorder_en_o = idle_off_q;
    assign nrz_data_o = nrz_q;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_idle_tick;
        st_q == SMP_IDLE && word_tick;
    endsequence
    sequence s_conv_start(logic [MUX_W-1:0] code);
        start_q && mux_q == code && st_q == SMP_CONV;
    endsequence

    a_sync_word_first: assert property (s_idle_tick and slot == SLOT_SYNC |=>
        word_q == FRAME_SYNC && st_q == SMP_PUSH) else $error("frame sync missing");
    a_fast_ll_select: assert property (s_idle_tick and slot >= SLOT_LL_FIRST
        && slot <= SLOT_LL_LAST |=> s_conv_start(MUX_LL_FAST + MUX_W'($past(slot) - 1'b1)))
        else $error("fast low-level select wrong");
    a_slow_ll_select: assert property (s_idle_tick and slot == SLOT_SLOW && minor == 3'h2
        |=> s_conv_start(MUX_LL_SLOW + 5'h02)) else $error("slow low-level select wrong");
    a_rate_channel: assert property (s_idle_tick and slot == SLOT_PRIME && pos == 6'h13
        |=> s_conv_start(MUX_HL_RATE + 5'h02)) else $error("rate channel select wrong");
    a_hl_sub_select: assert property (s_idle_tick and slot == SLOT_PRIME && pos == 6'h27
        |=> s_conv_start(MUX_HL_SUB + MUX_W'($past(hl_step)))) else $error("subcom select wrong");
    a_disc_word_a: assert property (s_idle_tick and slot == SLOT_PRIME && pos == POS_DISC_A
        |=> word_q == $past(disc_b_q[7:0])) else $error("discrete word wrong");
    a_conv_to_push: assert property (st_q == SMP_CONV && adc_valid_i |=>
        st_q == SMP_PUSH && word_q == $past(adc_data_i)) else $error("converted word lost");
    a_exec_held: assert property (disc_b_q[DISC_EXEC] |=> exec_q)
        else $error("execute pulse not held");
    a_shift_msb: assert property (bit_tick && bit_idx != '0 |=>
        nrz_q == $past(shift_q[WORD_W-2])) else $error("shift order wrong");
    a_load_word: assert property (bit_tick && bit_idx == '0 && fifo_out_valid |=>
        nrz_q == $past(fifo_out_data[WORD_W-1])) else $error("word load wrong");
    a_paths_off: assert property (!digital_sel_en_o && !recorder_en_o)
        else $error("unused path enabled");
    a_rate_follow: assert property (rate_b_q |=> rate_src_sel_o)
        else $error("rate source not followed");
endmodule
`default_nettype wire

// *** tb/tpcm_adc_model.sv ***
// Behavioural converter that answers each start with a word derived from its channel code.
`timescale 1ns/1ps
`default_nettype none
module tpcm_adc_model (
    // Request side.
    input wire logic core_clk_i,
    input wire logic start_i,
    input wire logic [4:0] mux_i,
    input wire logic slow_i,
    // Answer side.
    output logic valid_o,
    output logic [7:0] data_o
);
    int wait_q = 0;
    logic valid_q = 1'b0;
    logic [7:0] data_q = 8'h00;
    logic [7:0] word_q = 8'h00;
    // Slow answers still fit a word time; idle data toggles so no stale word looks valid.
    always @(posedge core_clk_i)
    begin
        valid_q <= 1'b0;
        data_q <= ~data_q;
        if (start_i)
        begin
            wait_q <= slow_i ? 140 : 1;
            word_q <= 8'(mux_i * 7 + 33);
        end
        else if (wait_q > 1)
            wait_q <= wait_q - 1;
        else if (wait_q == 1)
        begin
            wait_q <= 0;
            valid_q <= 1'b1;
            data_q <= word_q;
        end
    end
    assign valid_o = valid_q;
    assign data_o = data_q;
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the commutator: serial frames, rate select and restart after reset.
`timescale 1ns/1ps
`default_nettype none
module tb import tpcm_pkg::*;;
    logic core_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [18:0] disc = '0;
    logic cmd_exec = 1'b0;
    logic rate_sel = 1'b0;
    logic slow = 1'b0;
    logic rate_prev = 1'b0;
    logic rate_src, adc_start, adc_valid, dsel, rec, nrz;
    logic [4:0] adc_mux;
    logic [7:0] adc_data, sh;
    int seed, miscompares, checks, i, f, w, c, stab;
    // Clock of 4 ns.
    always #2 core_clk_i = ~core_clk_i;
    tpcm_top #(.BIT_CLKS(20)) u_dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
        .vehicle_separated_i(disc[0]), .cone_unlatched_i(disc[1]), .cone_locked_i(disc[2]),
        .craft_detached_i(disc[3]), .launch_config_ok_i(disc[4]),
        .shroud_jettisoned_i(disc[5]), .igniter_safe_i(disc[6]), .igniter_armed_i(disc[7]),
        .cmd_execute_pulse_i(cmd_exec), .thruster_ring_sel_i(disc[9]),
        .thruster_fire_n_i(disc[17:10]), .antenna_extended_i(disc[18]),
        .ground_command_link_rate_sel_i(rate_sel), .rate_src_sel_o(rate_src),
        .adc_start_o(adc_start), .adc_mux_o(adc_mux), .adc_valid_i(adc_valid),
        .adc_data_i(adc_data), .digital_sel_en_o(dsel), .recorder_en_o(rec), .nrz_data_o(nrz));
    tpcm_adc_model u_adc (.core_clk_i(core_clk_i), .start_i(adc_start), .mux_i(adc_mux),
        .slow_i(slow), .valid_o(adc_valid), .data_o(adc_data));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (miscompares == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Mid-bit sample, one bit period after the last one.
    task automatic get_bit();
        repeat (20) @(posedge core_clk_i);
        sh = {sh[6:0], nrz};
    endtask
    // One whole word off the line, most significant bit first.
    task automatic get_word();
        repeat (8) get_bit();
    endtask
    function automatic logic [7:0] adc_exp(input int code);
        return 8'(code * 7 + 33);
    endfunction
    // Expected word w of frame f; discrete bit 8 holds the latched execute pulse.
    function automatic logic [7:0] word_exp(input int f, input int w);
        int p;
        p = f % 64;
        case (w)
            0: return 8'hE4;
            1, 2, 3, 4, 5: return adc_exp(w - 1);
            6:
            begin
                if (p == 0)
                    return 8'h1B;
                if (p % 16 >= 1 && p % 16 <= 3)
                    return adc_exp(7 + p % 16);
                if (p == 4)
                    return disc[7:0];
                if (p == 5)
                    return disc[15:8];
                if (p == 6)
                    return {5'h00, disc[18:16]};
                return (p == 7 || p == 39) ? adc_exp(16 + f / 32 % 16) : 8'h55;
            end
            7: return (f % 8 <= 2) ? adc_exp(5 + f % 8) : 8'h55;
            8: return 8'(p);
            default: return 8'(f / 32 % 16);
        endcase
    endfunction
    // Random converter speed and occasional ground rate-select changes.
    always @(posedge core_clk_i)
    begin
        slow <= 1'($random(seed));
        if ($random(seed) % 50 == 0)
            rate_sel <= ~rate_sel;
    end
    // Once the select input has been steady, its registered copy must follow it.
    always @(negedge core_clk_i)
    begin
        if (arst_n_i && rate_prev === rate_sel)
            stab = stab + 1;
        else
            stab = 0;
        rate_prev = rate_sel;
        if (stab > 4)
        begin
            check("rate_src_sel", rate_src, rate_sel);
            check("unused_paths", {dsel, rec}, 2'h0);
        end
    end
    initial
    begin
        seed = 78;
        c = $random(seed);
        disc = 19'($random(seed));
        disc[0] = (c[0] & c[1]) | (c[1] & c[2]) | (c[0] & c[2]);
        disc[2] = &c[5:3];
        disc[4] = &c[9:6];
        disc[7] = ~disc[6];
        disc[8] = 1'b1;
        repeat (10) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        @(posedge core_clk_i);
        cmd_exec <= 1'b1;
        @(posedge core_clk_i);
        cmd_exec <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        sh = 8'h00;
        for (i = 0; i < 200 && sh !== 8'hE4; i++)
            get_bit();
        check("frame_sync", sh, 8'hE4);
        if (sh === 8'hE4)
        begin
            for (f = 0; f < 45; f++)
                for (w = (f == 0) ? 1 : 0; w < 10; w++)
                begin
                    get_word();
                    check($sformatf("word_f%0d_w%0d", f, w), sh, word_exp(f, w));
                end
        end
        // Mid-run reset, held past any slow conversion still pending in the converter.
        arst_n_i <= 1'b0;
        repeat (160) @(posedge core_clk_i);
        check("reset_outputs", {nrz, adc_start, rate_src, dsel, rec}, 5'h00);
        arst_n_i <= 1'b1;
        // First bit starts 21 clocks after release; sample each bit in its middle.
        repeat (10) @(posedge core_clk_i);
        get_word();
        check("restart_fill", sh, 8'h55);
        get_word();
        check("restart_sync", sh, 8'hE4);
        get_word();
        check("restart_first", sh, adc_exp(0));
        give_verdict();
    end
endmodule
`default_nettype wire
